// ===== pkg/drp_defs.svh
// Constants for the DMA request selection and channel priority block
// Contract
// - Per-channel request mode from resource select
// - Auto request runs when enabled, flags clear
// - External pin requests only on channels 0, 1
// - External request needs enables and clear flags
// - Resource select code picks dual or single mode
// - Level/edge bits pick request detection kind
// - Ignore request input until acknowledge driven
// - Overrun bit adds one extra level transfer
// - Peripheral request needs enables and clear flags
// - Decode module and register id; cycle steal
// - Requester need not be source or destination
// - Simultaneous requests served by priority field
// - Fixed orders 0123 or 0231
// - Round robin: finished channel drops to lowest
// - Rotation keeps cyclic channel order
// - Reset round robin order 0,1,2,3
// - Only legal source/destination pairings transfer
// - Selector request honoured only with code 1000
// - Count down per unit, end flag, interrupt
// - Abort on error, NMI or enable cleared
`ifndef DRP_DEFS_SVH
`define DRP_DEFS_SVH
`define DRP_ADDR_GRP 7:4
`define DRP_ADDR_IDX 3:2
`define DRP_ADDR_LSB 1:0
`define DRP_GRP_CTRL 4'h0
`define DRP_GRP_COUNT 4'h1
`define DRP_OFS_SEL_A 8'h20
`define DRP_OFS_SEL_B 8'h24
`define DRP_OFS_OPER 8'h28
`define DRP_CC_DE 0
`define DRP_CC_TE 1
`define DRP_CC_IE 2
`define DRP_CC_DO 3
`define DRP_CC_DS 4
`define DRP_CC_DL 5
`define DRP_CC_TB 6
`define DRP_CC_RS 11:8
`define DRP_CC_SRC 13:12
`define DRP_CC_DST 15:14
`define DRP_OP_DME 0
`define DRP_OP_NMI_FLAG 1
`define DRP_OP_AE 2
`define DRP_OP_PR 9:8
`define DRP_RS_EXT_DUAL 4'h0
`define DRP_RS_EXT_TODEV 4'h2
`define DRP_RS_EXT_FROMDEV 4'h3
`define DRP_RS_AUTO 4'h4
`define DRP_RS_PERIPH 4'h8
`define DRP_MID_SER0 6'h08
`define DRP_MID_SER1 6'h09
`define DRP_MID_SER2 6'h0a
`define DRP_MID_SIO0 6'h14
`define DRP_RID_TX 2'h1
`define DRP_RID_RX 2'h2
`define DRP_PR_FIXED_A 2'h0
`define DRP_PR_FIXED_B 2'h1
`define DRP_ORDER_A 8'he4
`define DRP_ORDER_B 8'h78
`define DRP_KIND_ACKDEV 2'h0
`define DRP_KIND_MEM 2'h1
`define DRP_KIND_MMDEV 2'h2
`define DRP_KIND_ONCHIP 2'h3
`define DRP_COUNT_ONE 24'h00_0001
`define DRP_RDATA_ZERO 32'h0000_0000
`define DRP_EXT_CHANNELS 2
`endif

// ===== pkg/drp_pkg.sv
// Types shared by the DMA request and priority block
`default_nettype none
package drp_pkg;
	typedef enum logic [1:0] {DRP_ARMED, DRP_WAIT_ACK, DRP_HOLD, DRP_DRAIN} drp_ext_st_e;
	typedef enum logic {DRP_IDLE, DRP_BUSY} drp_top_st_e;
	typedef struct packed {
		logic sync1;
		logic sync2;
		logic prev;
		logic edge_seen;
		logic req;
		drp_ext_st_e st;
	} drp_ext_s;
	typedef struct packed {
		logic [1:0] top;
	} drp_arb_s;
	typedef struct packed {
		drp_top_st_e st;
		logic [3:0][15:0] ctrl;
		logic [3:0][23:0] count;
		logic [1:0][15:0] sel;
		logic [15:0] oper;
		logic [1:0] ch;
		logic single;
		logic to_dev;
		logic burst;
		logic [1:0] ack;
		logic abort;
		logic [31:0] rdata;
	} drp_top_s;
endpackage
`default_nettype wire

// ===== pkg/drp_arb_if.sv
// Link between the request front end and the channel arbiter
`default_nettype none
interface drp_arb_if;
	logic [3:0] req;
	logic [1:0] mode;
	logic done;
	logic [1:0] done_ch;
	logic gnt_valid;
	logic [1:0] gnt_ch;
	modport ctl(output req, output mode, output done, output done_ch,
		input gnt_valid, input gnt_ch);
	modport arb(input req, input mode, input done, input done_ch,
		output gnt_valid, output gnt_ch);
endinterface
`default_nettype wire

// ===== core/drp_ext_req.sv
// External request pin detector for one channel
`include "drp_defs.svh"
`default_nettype none
module drp_ext_req (
	input wire logic clk,
	input wire logic rst,
	input wire logic pin,
	input wire logic enable,
	input wire logic level_sel,
	input wire logic edge_sel,
	input wire logic overrun,
	input wire logic ack,
	output logic req
);
	drp_pkg::drp_ext_s s;
	drp_pkg::drp_ext_s next_s;

	always_comb begin
		logic active;
		logic event_now;
		active = 1'b0;
		event_now = 1'b0;
		next_s = s;
		next_s.sync1 = pin;
		next_s.sync2 = s.sync1;
		next_s.prev = s.sync2;
		active = level_sel ? s.sync2 : !s.sync2;
		event_now = edge_sel && (active && (level_sel ? !s.prev : s.prev));
		unique case (s.st)
			drp_pkg::DRP_ARMED: begin
				if (event_now) begin
					next_s.edge_seen = 1'b1;
				end
				if (enable && (edge_sel ? (event_now || s.edge_seen) : active)) begin
					next_s.req = 1'b1;
					next_s.edge_seen = 1'b0;
					next_s.st = drp_pkg::DRP_WAIT_ACK;
				end
			end
			drp_pkg::DRP_WAIT_ACK: begin
				if (!enable) begin
					next_s.req = 1'b0;
					next_s.st = drp_pkg::DRP_ARMED;
				end else if (ack) begin
					next_s.req = 1'b0;
					// Level mode with overrun 0 lets both sync stages drain so a pin dropped on the ack is not resampled
					next_s.st = (!edge_sel && !overrun) ? drp_pkg::DRP_HOLD
						: drp_pkg::DRP_ARMED;
				end
			end
			drp_pkg::DRP_HOLD: begin
				next_s.st = drp_pkg::DRP_DRAIN;
			end
			drp_pkg::DRP_DRAIN: begin
				next_s.st = drp_pkg::DRP_ARMED;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign req = s.req;
endmodule
`default_nettype wire

// ===== core/drp_arbiter.sv
// Fixed and round-robin channel arbiter
`include "drp_defs.svh"
`default_nettype none
module drp_arbiter (
	input wire logic clk,
	input wire logic rst,
	drp_arb_if.arb bus
);
	drp_pkg::drp_arb_s s;
	drp_pkg::drp_arb_s next_s;

	// Slot 0 in the low bits is the highest priority; returns {hit, channel}
	function automatic logic [2:0] pick(input logic [3:0] req, input logic [7:0] order);
		logic [2:0] r;
		r = 3'b000;
		for (int k = 3; k >= 0; k--) begin
			if (req[order[2*k +: 2]]) begin
				r = {1'b1, order[2*k +: 2]};
			end
		end
		return r;
	endfunction

	always_comb begin
		logic [7:0] order;
		logic [2:0] hit;
		logic rr;
		order = `DRP_ORDER_A;
		hit = 3'b000;
		rr = 1'b0;
		next_s = s;
		unique case (bus.mode)
			`DRP_PR_FIXED_A: order = `DRP_ORDER_A;
			`DRP_PR_FIXED_B: order = `DRP_ORDER_B;
			default: begin
				rr = 1'b1;
				order = {2'(s.top + 2'd3), 2'(s.top + 2'd2), 2'(s.top + 2'd1), s.top};
			end
		endcase
		hit = pick(bus.req, order);
		bus.gnt_valid = hit[2];
		bus.gnt_ch = hit[1:0];
		if (rr && bus.done) begin
			next_s.top = 2'(bus.done_ch + 2'd1);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule
`default_nettype wire

// ===== core/drp_top.sv
// Request selection, enable checking and channel sequencing for four DMA channels
`include "drp_defs.svh"
`default_nettype none
module drp_top (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [1:0] external_request_in,
	output logic [1:0] request_acknowledge_out,
	input wire logic [3:0] periph_tx_empty,
	input wire logic [3:0] periph_rx_full,
	input wire logic nmi_in,
	input wire logic addr_err_in,
	output logic unit_valid,
	output logic [1:0] unit_ch,
	output logic unit_single,
	output logic unit_to_dev,
	output logic unit_burst,
	input wire logic unit_done,
	output logic unit_abort,
	output logic [3:0] transfer_end_interrupt
);
	drp_pkg::drp_top_s s;
	drp_pkg::drp_top_s next_s;
	drp_arb_if arb_bus();
	logic [3:0] ok;
	logic [3:0] chan_req;
	logic [3:0] ext_req;
	logic [3:0] ext_live;
	logic [1:0] ext_en;

	// Enable conditions shared by every request mode
	function automatic logic chan_ready(input logic [15:0] ctrl, input logic [15:0] oper);
		return ctrl[`DRP_CC_DE] && oper[`DRP_OP_DME] && !ctrl[`DRP_CC_TE]
			&& !oper[`DRP_OP_AE] && !oper[`DRP_OP_NMI_FLAG];
	endfunction

	function automatic logic is_ext(input logic [3:0] rs);
		return rs == `DRP_RS_EXT_DUAL || rs == `DRP_RS_EXT_TODEV
			|| rs == `DRP_RS_EXT_FROMDEV;
	endfunction

	function automatic logic is_single(input logic [3:0] rs);
		return rs == `DRP_RS_EXT_TODEV || rs == `DRP_RS_EXT_FROMDEV;
	endfunction

	function automatic logic is_memlike(input logic [1:0] k);
		return k == `DRP_KIND_MEM || k == `DRP_KIND_MMDEV;
	endfunction

	// Endpoint pairings that the engine can really carry out
	function automatic logic xfer_legal(input logic [3:0] rs, input logic [1:0] src,
		input logic [1:0] dst);
		logic r;
		r = 1'b1;
		if (rs == `DRP_RS_EXT_TODEV) begin
			r = is_memlike(src) && dst == `DRP_KIND_ACKDEV;
		end else if (rs == `DRP_RS_EXT_FROMDEV) begin
			r = src == `DRP_KIND_ACKDEV && is_memlike(dst);
		end else if (src == `DRP_KIND_ACKDEV) begin
			r = rs == `DRP_RS_EXT_DUAL && is_memlike(dst);
		end else if (dst == `DRP_KIND_ACKDEV) begin
			r = rs == `DRP_RS_EXT_DUAL && is_memlike(src);
		end
		return r;
	endfunction

	// Selector byte: module id above, register id in the two low bits
	function automatic logic periph_hit(input logic [7:0] sel, input logic [3:0] tx,
		input logic [3:0] rx);
		logic [3:0] pick;
		logic r;
		pick = 4'h0;
		r = 1'b0;
		if (sel[1:0] == `DRP_RID_TX) begin
			pick = tx;
		end else if (sel[1:0] == `DRP_RID_RX) begin
			pick = rx;
		end
		case (sel[7:2])
			`DRP_MID_SER0: r = pick[0];
			`DRP_MID_SER1: r = pick[1];
			`DRP_MID_SER2: r = pick[2];
			`DRP_MID_SIO0: r = pick[3];
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	for (genvar i = 0; i < 4; i++) begin : g_chan
		logic [3:0] rs;
		logic ext_hit;
		logic per_hit;
		assign rs = s.ctrl[i][`DRP_CC_RS];
		assign ok[i] = chan_ready(s.ctrl[i], s.oper)
			&& xfer_legal(rs, s.ctrl[i][`DRP_CC_SRC], s.ctrl[i][`DRP_CC_DST]);
		assign ext_hit = is_ext(rs) && ext_live[i];
		assign per_hit = rs == `DRP_RS_PERIPH
			&& periph_hit(s.sel[i/2][(i%2)*8 +: 8], periph_tx_empty, periph_rx_full);
		assign chan_req[i] = ok[i] && (rs == `DRP_RS_AUTO || ext_hit || per_hit);
	end

	// Only the first two channels own request pins
	for (genvar i = 0; i < `DRP_EXT_CHANNELS; i++) begin : g_ext
		assign ext_en[i] = ok[i] && is_ext(s.ctrl[i][`DRP_CC_RS]);
		drp_ext_req u_ext (
			.clk(clk),
			.rst(rst),
			.pin(external_request_in[i]),
			.enable(ext_en[i]),
			.level_sel(s.ctrl[i][`DRP_CC_DL]),
			.edge_sel(s.ctrl[i][`DRP_CC_DS]),
			.overrun(s.ctrl[i][`DRP_CC_DO]),
			.ack(s.ack[i]),
			.req(ext_req[i])
		);
	end
	assign ext_req[3:2] = 2'b00;
	// An accepted pin request is hidden while its ack is out, else the idle cycle regrants it
	assign ext_live = ext_req & {2'b00, ~s.ack};

	// A channel in service is not offered again until its unit ends
	assign arb_bus.req = (s.st == drp_pkg::DRP_IDLE) ? chan_req : 4'h0;
	assign arb_bus.mode = s.oper[`DRP_OP_PR];
	assign arb_bus.done = s.st == drp_pkg::DRP_BUSY && unit_done && ok[s.ch];
	assign arb_bus.done_ch = s.ch;

	drp_arbiter u_arb (
		.clk(clk),
		.rst(rst),
		.bus(arb_bus.arb)
	);

	always_comb begin
		logic [3:0] rs;
		rs = 4'h0;
		next_s = s;
		next_s.ack = 2'b00;
		next_s.abort = 1'b0;
		next_s.rdata = `DRP_RDATA_ZERO;

		// Software writes first so that hardware flag sets below win
		if (reg_wr && reg_addr[`DRP_ADDR_LSB] == 2'b00) begin
			if (reg_addr[`DRP_ADDR_GRP] == `DRP_GRP_CTRL) begin
				next_s.ctrl[reg_addr[`DRP_ADDR_IDX]] = reg_wdata[15:0];
				next_s.ctrl[reg_addr[`DRP_ADDR_IDX]][`DRP_CC_TE] =
					s.ctrl[reg_addr[`DRP_ADDR_IDX]][`DRP_CC_TE] && reg_wdata[`DRP_CC_TE];
			end else if (reg_addr[`DRP_ADDR_GRP] == `DRP_GRP_COUNT) begin
				next_s.count[reg_addr[`DRP_ADDR_IDX]] = reg_wdata[23:0];
			end else if (reg_addr == `DRP_OFS_SEL_A) begin
				next_s.sel[0] = reg_wdata[15:0];
			end else if (reg_addr == `DRP_OFS_SEL_B) begin
				next_s.sel[1] = reg_wdata[15:0];
			end else if (reg_addr == `DRP_OFS_OPER) begin
				next_s.oper = reg_wdata[15:0];
				next_s.oper[`DRP_OP_NMI_FLAG] = s.oper[`DRP_OP_NMI_FLAG] && reg_wdata[`DRP_OP_NMI_FLAG];
				next_s.oper[`DRP_OP_AE] = s.oper[`DRP_OP_AE] && reg_wdata[`DRP_OP_AE];
			end
		end

		if (nmi_in) begin
			next_s.oper[`DRP_OP_NMI_FLAG] = 1'b1;
		end
		if (addr_err_in) begin
			next_s.oper[`DRP_OP_AE] = 1'b1;
		end

		unique case (s.st)
			drp_pkg::DRP_IDLE: begin
				if (arb_bus.gnt_valid) begin
					rs = s.ctrl[arb_bus.gnt_ch][`DRP_CC_RS];
					next_s.st = drp_pkg::DRP_BUSY;
					next_s.ch = arb_bus.gnt_ch;
					next_s.single = is_single(rs);
					next_s.to_dev = rs == `DRP_RS_EXT_TODEV;
					// Peripheral requests always cycle-steal
					next_s.burst = s.ctrl[arb_bus.gnt_ch][`DRP_CC_TB]
						&& rs != `DRP_RS_PERIPH;
				end
			end
			drp_pkg::DRP_BUSY: begin
				if (!ok[s.ch]) begin
					next_s.st = drp_pkg::DRP_IDLE;
					next_s.abort = 1'b1;
				end else if (unit_done) begin
					next_s.st = drp_pkg::DRP_IDLE;
					next_s.count[s.ch] = s.count[s.ch] - `DRP_COUNT_ONE;
					if (s.count[s.ch] == `DRP_COUNT_ONE) begin
						next_s.ctrl[s.ch][`DRP_CC_TE] = 1'b1;
					end
					if (s.ch < 2'(`DRP_EXT_CHANNELS) && is_ext(s.ctrl[s.ch][`DRP_CC_RS])) begin
						next_s.ack[s.ch[0]] = 1'b1;
					end
				end
			end
		endcase

		if (reg_rd) begin
			if (reg_addr[`DRP_ADDR_LSB] != 2'b00) begin
				next_s.rdata = `DRP_RDATA_ZERO;
			end else if (reg_addr[`DRP_ADDR_GRP] == `DRP_GRP_CTRL) begin
				next_s.rdata = {16'h0000, s.ctrl[reg_addr[`DRP_ADDR_IDX]]};
			end else if (reg_addr[`DRP_ADDR_GRP] == `DRP_GRP_COUNT) begin
				next_s.rdata = {8'h00, s.count[reg_addr[`DRP_ADDR_IDX]]};
			end else if (reg_addr == `DRP_OFS_SEL_A) begin
				next_s.rdata = {16'h0000, s.sel[0]};
			end else if (reg_addr == `DRP_OFS_SEL_B) begin
				next_s.rdata = {16'h0000, s.sel[1]};
			end else if (reg_addr == `DRP_OFS_OPER) begin
				next_s.rdata = {16'h0000, s.oper};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign reg_rdata = s.rdata;
	assign request_acknowledge_out = s.ack;
	assign unit_valid = s.st == drp_pkg::DRP_BUSY;
	assign unit_ch = s.ch;
	assign unit_single = s.single;
	assign unit_to_dev = s.to_dev;
	assign unit_burst = s.burst;
	assign unit_abort = s.abort;

	for (genvar i = 0; i < 4; i++) begin : g_irq
		assign transfer_end_interrupt[i] = s.ctrl[i][`DRP_CC_TE] && s.ctrl[i][`DRP_CC_IE];
	end
endmodule
`default_nettype wire

// ===== bench/drp_chk.sv
// Port checker for the DMA request and priority block
`default_nettype none
module drp_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic [1:0] request_acknowledge_out,
	input wire logic nmi_in,
	input wire logic unit_valid,
	input wire logic [1:0] unit_ch,
	input wire logic unit_single,
	input wire logic unit_to_dev,
	input wire logic unit_done,
	input wire logic unit_abort
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence unit_end;
		unit_valid && unit_done;
	endsequence
	sequence unit_held;
		unit_valid && !unit_done && !unit_abort;
	endsequence
	unit_stands_a: assert property (unit_held |=>
		unit_abort || (unit_valid && $stable(unit_ch)))
		else $error("unit dropped or changed channel");
	end_gap_a: assert property (unit_end |=> !unit_valid)
		else $error("no idle cycle after unit end");
	ack_zero_a: assert property (request_acknowledge_out[0] |->
		$past(unit_valid && unit_done && unit_ch == 2'h0)) else $error("stray ack 0");
	ack_one_a: assert property (request_acknowledge_out[1] |->
		$past(unit_valid && unit_done && unit_ch == 2'h1)) else $error("stray ack 1");
	single_ext_a: assert property (unit_valid && unit_single |-> !unit_ch[1])
		else $error("single mode on channel 2 or 3");
	to_dev_a: assert property (unit_valid && unit_to_dev |-> unit_single)
		else $error("direction without single mode");
	abort_drop_a: assert property (unit_abort |=> !unit_valid)
		else $error("unit kept after abort");
	nmi_stop_a: assert property ((unit_held and nmi_in) |-> ##[1:3] !unit_valid)
		else $error("unit not stopped by nmi");
endmodule
`default_nettype wire

// ===== bench/drp_far_model.sv
// Far side: transfer engine answering units and one pin requester
`default_nettype none
module drp_far_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic unit_valid,
	input wire logic [1:0] request_acknowledge_out,
	input wire logic [3:0] lat,
	input wire logic load,
	input wire logic [3:0] load_cnt,
	output logic unit_done,
	output logic [1:0] external_request_in
);
	logic [3:0] wait_cnt;
	logic [3:0] pend;
	always @(posedge clk) begin
		if (rst || !unit_valid || unit_done) begin
			wait_cnt <= 4'h0;
			unit_done <= 1'b0;
		end else begin
			wait_cnt <= wait_cnt + 4'h1;
			unit_done <= (wait_cnt == lat);
		end
	end
	// Holds its request until acknowledged, so overrun is visible
	always @(posedge clk) begin
		if (rst)
			pend <= 4'h0;
		else if (load)
			pend <= load_cnt;
		else if (request_acknowledge_out[0] && pend != 4'h0)
			pend <= pend - 4'h1;
	end
	assign external_request_in = {1'b0, pend != 4'h0};
endmodule
`default_nettype wire

// ===== bench/drp_top_tb.sv
// Self-checking bench for the DMA request and priority block
`default_nettype none
module drp_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst = 1, wr = 0, rd = 0, nmi = 0, aerr = 0, load = 0, done, abrt, uv;
	logic us, ut, ub, last = 0;
	logic [7:0] addr = 0;
	logic [31:0] wd = 0, rdat;
	logic [1:0] ack, pin, uch, grants[$];
	logic [3:0] tx = 0, rx = 0, tei, lat = 2, lcnt = 0;
	int err_total = 0, checks = 0, acks = 0, bursts = 0, singles = 0;
	always #10 clk = ~clk;
	drp_top drp_top_inst (.clk(clk), .rst(rst), .reg_addr(addr), .reg_wdata(wd),
		.reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .external_request_in(pin),
		.request_acknowledge_out(ack), .periph_tx_empty(tx), .periph_rx_full(rx),
		.nmi_in(nmi), .addr_err_in(aerr), .unit_valid(uv), .unit_ch(uch),
		.unit_single(us), .unit_to_dev(ut), .unit_burst(ub), .unit_done(done),
		.unit_abort(abrt), .transfer_end_interrupt(tei));
	drp_far_model drp_far_model_inst (.clk(clk), .rst(rst), .unit_valid(uv),
		.request_acknowledge_out(ack), .lat(lat), .load(load), .load_cnt(lcnt),
		.unit_done(done), .external_request_in(pin));
	always @(posedge clk) begin
		last <= uv;
		if (uv && !last)
			grants.push_back(uch);
		if (ack[0])
			acks++;
		if (uv && ub)
			bursts++;
		if (uv && !last && us && ut)
			singles++;
	end
	task eq(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task w(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task r(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		eq(rdat, exp);
	endtask
	// Bounded wait for twelve idle cycles in a row
	task quiet;
		int n, k;
		n = 0;
		for (k = 0; k < 600 && n < 12; k++) begin
			@(posedge clk);
			n = uv ? 0 : n + 1;
		end
		eq(n, 12);
	endtask
	// Grant history packed two bits a grant behind a leading one
	task seq(input logic [31:0] exp);
		logic [31:0] v;
		v = 1;
		foreach (grants[i])
			v = {v[29:0], grants[i]};
		eq(v, exp);
		grants.delete();
	endtask
	task pins(input logic [3:0] c);
		@(posedge clk);
		load <= 1'b1;
		lcnt <= c;
		@(posedge clk);
		load <= 1'b0;
	endtask
	task clr;
		for (int i = 0; i < 4; i++)
			w(8'(4 * i), 0);
	endtask
	task t_reset;
		r(8'h28, 0);
		r(8'h00, 0);
		r(8'h80, 0);
	endtask
	task t_auto;
		w(8'h18, 2);
		w(8'h28, 1);
		w(8'h08, 32'h0000_5405);
		quiet;
		seq(32'h0000_001a);
		r(8'h18, 0);
		r(8'h08, 32'h0000_5407);
		eq(tei, 4'h4);
		clr;
	endtask
	// Channels armed with master enable off so the requests meet at once
	task arb(input logic [15:0] pr, input logic [3:0] chs, input logic [31:0] exp);
		w(8'h28, pr);
		for (int i = 0; i < 4; i++) begin
			w(8'(8'h10 + 4 * i), pr[9] ? 32'h0000_0002 : 32'h0000_0001);
			w(8'(4 * i), chs[i] ? 32'h0000_5401 : 0);
		end
		w(8'h28, pr | 1);
		quiet;
		seq(exp);
		clr;
	endtask
	task t_ext;
		acks = 0;
		w(8'h10, 10);
		w(8'h00, 32'h0000_5021);
		pins(3);
		quiet;
		seq(32'h0000_0040);
		eq(acks, 3);
		r(8'h10, 7);
		w(8'h00, 32'h0000_5031);
		pins(3);
		quiet;
		seq(32'h0000_0004);
		pins(0);
		w(8'h00, 32'h0000_5029);
		acks = 0;
		pins(2);
		quiet;
		seq(32'h0000_0040);
		eq(acks, 3);
		r(8'h10, 3);
		w(8'h00, 32'h0000_1211);
		pins(1);
		pins(0);
		quiet;
		seq(32'h0000_0004);
		eq(singles, 1);
		clr;
	endtask
	task t_abort;
		lat = 6;
		w(8'h28, 1);
		for (int i = 0; i < 2; i++) begin
			w(8'h18, 100);
			w(8'h08, 32'h0000_5405);
			for (int k = 0; k < 50 && !uv; k++)
				@(posedge clk);
			{aerr, nmi} <= 2'(1 << i);
			@(posedge clk);
			{aerr, nmi} <= 2'b00;
			quiet;
			r(8'h28, 1 | (2 << i));
			eq(tei, 0);
			w(8'h08, 0);
			w(8'h28, 1);
			grants.delete();
		end
		lat = 2;
	endtask
	task t_periph;
		w(8'h1c, 1);
		w(8'h20, 32'h0000_2100);
		w(8'h24, 32'h0000_2100);
		w(8'h04, 32'h0000_5021);
		w(8'h08, 32'h0000_5021);
		w(8'h0c, 32'h0000_d841);
		tx <= 4'h1;
		pins(1);
		quiet;
		seq(32'h0000_0007);
		eq(bursts, 0);
		tx <= 4'h0;
		w(8'h1c, 1);
		w(8'h24, 32'h0000_2200);
		w(8'h0c, 32'h0000_7801);
		rx <= 4'h1;
		quiet;
		seq(32'h0000_0007);
		rx <= 4'h0;
		pins(0);
		clr;
	endtask
	task close_out;
		$display("errors %0d checks %0d", err_total, checks);
		if (err_total == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_auto;
		arb(16'h0100, 4'he, 32'h0000_006d);
		arb(16'h0000, 4'he, 32'h0000_005b);
		arb(16'h0200, 4'hb, 32'h0000_11c7);
		t_ext;
		t_abort;
		t_periph;
		close_out;
	end
	initial begin
		#400000;
		err_total++;
		close_out;
	end
endmodule
bind drp_top drp_chk drp_chk_inst (.clk(clk), .rst(rst),
	.request_acknowledge_out(request_acknowledge_out), .nmi_in(nmi_in),
	.unit_valid(unit_valid), .unit_ch(unit_ch), .unit_single(unit_single),
	.unit_to_dev(unit_to_dev), .unit_done(unit_done), .unit_abort(unit_abort));
`default_nettype wire
